// file: rtl/agpc_pkg.sv
package agpc_pkg;

	// ----------------------------------------------------------------
	// register map (word index on the slave address)
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_CURRENT = 3'h1;
	localparam logic [2:0] ADDR_TIMING = 3'h2;
	localparam logic [2:0] ADDR_TARGET = 3'h3;
	localparam logic [2:0] ADDR_STATUS = 3'h4;

	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_AFW = 1;
	localparam int CTRL_LOW_MAP = 2;
	localparam int CTRL_AGC = 3;
	localparam int CTRL_FILT = 5;
	localparam int CTRL_STEP = 6;
	localparam int CTRL_SPLIT = 7;

	localparam int CUR_MAX = 0;
	localparam int CUR_INIT_CHG = 8;
	localparam int CUR_INIT_DIS = 16;
	localparam int CUR_MAIN = 24;

	localparam int TIM_PRE = 0;
	localparam int TIM_PREDIS = 8;
	localparam int TIM_GUARD = 16;

	localparam int TGT_ON = 0;
	localparam int TGT_OFF = 8;

	localparam int STS_EFF_ON = 0;
	localparam int STS_EFF_OFF = 8;
	localparam int STS_PREDIS = 16;
	localparam int STS_PRE = 24;
	localparam int STS_INREG = 31;

	// ----------------------------------------------------------------
	// reset values and fixed counts
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h1A;
	localparam logic [31:0] CURRENT_RESET = 32'h103F_103F;
	localparam logic [31:0] TIMING_RESET = 32'h0010_0808;
	localparam logic [31:0] TARGET_RESET = 32'h0000_0A0A;
	localparam logic [5:0] CODE_LOWEST = 6'h00;
	localparam logic [3:0] MATCH_MAX = 4'hF;
	localparam logic [3:0] MATCH_REG = 4'h8;
	localparam logic [1:0] FLIPS_REG = 2'h3;
	localparam logic [7:0] DELAY_MAX = 8'hFF;

	localparam logic [1:0] AGC_NONE = 2'h0;
	localparam logic [1:0] AGC_INIT = 2'h1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [7:0] {
		ST_OFF = 8'h01,
		ST_GUARD = 8'h02,
		ST_PRECHG = 8'h04,
		ST_CHARGE = 8'h08,
		ST_ON = 8'h10,
		ST_SYM = 8'h20,
		ST_PREDIS = 8'h40,
		ST_DISCHG = 8'h80
	} agpc_state_type;

	typedef struct packed {
		logic read;
		logic write;
		logic [2:0] address;
		logic [31:0] writedata;
	} agpc_av_req_type;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} agpc_av_rsp_type;

	typedef struct packed {
		logic chg;
		logic dis;
		logic [5:0] code;
	} agpc_gate_type;

endpackage

// file: rtl/agpc_top.sv
`timescale 1ns/1ns
module agpc_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire agpc_pkg::agpc_av_req_type avs_req,
	output agpc_pkg::agpc_av_rsp_type avs_rsp,
	input wire logic pwm_in,
	input wire logic sw_node_high_in,
	input wire logic sw_node_low_in,
	output agpc_pkg::agpc_gate_type hs_gate,
	output agpc_pkg::agpc_gate_type ls_gate
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic pwm_d;
		logic [7:0] ctrl;
		logic [31:0] current;
		logic [31:0] timing;
		logic [31:0] target;
		agpc_pkg::agpc_state_type st;
		logic [7:0] cnt;
		logic [7:0] gcnt;
		logic [7:0] dly;
		logic crossed;
		logic [7:0] eff_on;
		logic [7:0] eff_off;
		logic [1:0] hist_on;
		logic [1:0] hist_off;
		logic [5:0] pre_cur;
		logic [5:0] predis_cur;
		logic [3:0] match_on;
		logic [3:0] match_off;
		logic [1:0] flips_on;
		logic [1:0] flips_off;
		logic [1:0] sign_on;
		logic [1:0] sign_off;
		logic in_reg;
		logic fw_on;
		agpc_pkg::agpc_gate_type hs;
		agpc_pkg::agpc_gate_type ls;
		logic wait_r;
		logic [31:0] rdata;
	} agpc_regs_type;

	agpc_regs_type s_r;
	agpc_regs_type s_nxt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// hist bit 1 = longer than target, bit 0 = shorter
	function automatic logic [5:0] adapt(input logic [5:0] cur, input logic [1:0] now, input logic [1:0] prev,
		input logic filt, input logic two, input logic [5:0] maxc);
		logic up;
		logic dn;
		logic [6:0] step;
		logic [6:0] sum;
		up = filt ? (now[1] && prev[1]) : now[1];
		dn = filt ? (now[0] && prev[0]) : now[0];
		step = two ? 7'h02 : 7'h01;
		sum = {1'b0, cur};
		if (up) begin
			sum = sum + step;
		end else if (dn) begin
			sum = (sum > step) ? (sum - step) : {1'b0, agpc_pkg::CODE_LOWEST};
		end
		// neither case: code stays as it was
		if (sum > {1'b0, maxc}) begin
			sum = {1'b0, maxc};
		end
		adapt = sum[5:0];
	endfunction

	function automatic logic [1:0] compare(input logic [7:0] meas, input logic [7:0] tgt);
		compare = {meas > tgt, meas < tgt};
	endfunction

	function automatic logic [3:0] match_step(input logic [3:0] c, input logic eq);
		if (eq) begin
			match_step = (c == agpc_pkg::MATCH_MAX) ? c : c + 4'h1;
		end else begin
			match_step = (c == 4'h0) ? c : c - 4'h1;
		end
	endfunction

	// sign held as {valid, positive}; zero error breaks no run
	function automatic logic [1:0] flip_step(input logic [1:0] f, input logic [1:0] last, input logic [1:0] cmp);
		if (cmp == 2'b00) begin
			flip_step = f;
		end else if (last[1] && (last[0] != cmp[1])) begin
			flip_step = (f == agpc_pkg::FLIPS_REG) ? f : f + 2'h1;
		end else begin
			flip_step = 2'h0;
		end
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic pwm_s;
	logic near_hit;
	logic far_hit;
	logic [1:0] adaptive_control_select;
	logic [5:0] maxc;
	logic [5:0] main_code;
	logic [5:0] pre_code;
	logic [5:0] predis_code;
	logic [7:0] guard_t;
	logic [7:0] pre_t;
	logic [7:0] predis_t;
	logic [1:0] cmp_on;
	logic [1:0] cmp_off;
	logic [7:0] off_meas;
	logic rise;
	logic fall;
	logic en_rise;
	agpc_pkg::agpc_gate_type pg;
	agpc_pkg::agpc_gate_type fg;

	always_comb begin
		s_nxt = s_r;
		pwm_s = s_r.sync2[0];
		// low-side mapping turns the switch-node thresholds round
		near_hit = s_r.ctrl[agpc_pkg::CTRL_LOW_MAP] ? s_r.sync2[2] : s_r.sync2[1];
		far_hit = s_r.ctrl[agpc_pkg::CTRL_LOW_MAP] ? s_r.sync2[1] : s_r.sync2[2];
		adaptive_control_select = s_r.ctrl[agpc_pkg::CTRL_AGC +: 2];
		maxc = s_r.current[agpc_pkg::CUR_MAX +: 6];
		main_code = s_r.current[agpc_pkg::CUR_MAIN +: 6];
		guard_t = s_r.timing[agpc_pkg::TIM_GUARD +: 8];
		pre_t = s_r.timing[agpc_pkg::TIM_PRE +: 8];
		predis_t = s_r.timing[agpc_pkg::TIM_PREDIS +: 8];
		pre_code = (adaptive_control_select == agpc_pkg::AGC_INIT) ? s_r.current[agpc_pkg::CUR_INIT_CHG +: 6] : s_r.pre_cur;
		predis_code = (adaptive_control_select == agpc_pkg::AGC_INIT) ? s_r.current[agpc_pkg::CUR_INIT_DIS +: 6] : s_r.predis_cur;
		rise = pwm_s && !s_r.pwm_d;
		fall = !pwm_s && s_r.pwm_d;
		en_rise = 1'b0;
		cmp_on = compare(s_r.eff_on, s_r.target[agpc_pkg::TGT_ON +: 8]);
		off_meas = s_r.dly;
		cmp_off = 2'b00;
		pg = '{chg: 1'b0, dis: 1'b1, code: main_code};
		fg = '{chg: 1'b0, dis: 1'b1, code: main_code};

		s_nxt.sync1 = {sw_node_low_in, sw_node_high_in, pwm_in};
		s_nxt.sync2 = s_r.sync1;
		s_nxt.pwm_d = pwm_s;
		if (s_r.dly != agpc_pkg::DELAY_MAX) begin
			s_nxt.dly = s_r.dly + 8'h01;
		end

		// ---------------- register slave ----------------
		// one wait cycle per access; write lands on the edge that sees waitrequest low
		s_nxt.wait_r = !((avs_req.read || avs_req.write) && s_r.wait_r);
		if (avs_req.write && !s_r.wait_r) begin
			unique case (avs_req.address)
				agpc_pkg::ADDR_CTRL: begin
					s_nxt.ctrl = avs_req.writedata[7:0];
					en_rise = avs_req.writedata[agpc_pkg::CTRL_ENABLE] && !s_r.ctrl[agpc_pkg::CTRL_ENABLE];
				end
				agpc_pkg::ADDR_CURRENT: s_nxt.current = avs_req.writedata & 32'h3F3F_3F3F;
				agpc_pkg::ADDR_TIMING: s_nxt.timing = {8'h00, avs_req.writedata[23:0]};
				agpc_pkg::ADDR_TARGET: s_nxt.target = {16'h0000, avs_req.writedata[15:0]};
				default: ;
			endcase
		end
		s_nxt.rdata = 32'h0000_0000;
		unique case (avs_req.address)
			agpc_pkg::ADDR_CTRL: s_nxt.rdata = {24'h00_0000, s_r.ctrl};
			agpc_pkg::ADDR_CURRENT: s_nxt.rdata = s_r.current;
			agpc_pkg::ADDR_TIMING: s_nxt.rdata = s_r.timing;
			agpc_pkg::ADDR_TARGET: s_nxt.rdata = s_r.target;
			agpc_pkg::ADDR_STATUS: begin
				s_nxt.rdata[agpc_pkg::STS_EFF_ON +: 8] = s_r.eff_on;
				s_nxt.rdata[agpc_pkg::STS_EFF_OFF +: 8] = s_r.eff_off;
				s_nxt.rdata[agpc_pkg::STS_PREDIS +: 6] = s_r.predis_cur;
				s_nxt.rdata[agpc_pkg::STS_PRE +: 6] = s_r.pre_cur;
				s_nxt.rdata[agpc_pkg::STS_INREG] = s_r.in_reg;
			end
			default: ;
		endcase

		// ---------------- phase sequencer ----------------
		unique case (s_r.st)
			agpc_pkg::ST_OFF: begin
				if (s_r.fw_on) begin
					fg = '{chg: 1'b1, dis: 1'b0, code: main_code};
				end
				if (rise) begin
					s_nxt.fw_on = 1'b0;
					s_nxt.dly = 8'h00;
					if (s_r.ctrl[agpc_pkg::CTRL_AFW]) begin
						s_nxt.st = agpc_pkg::ST_GUARD;
						s_nxt.cnt = guard_t;
					end else if (adaptive_control_select == agpc_pkg::AGC_NONE || pre_t == 8'h00) begin
						s_nxt.st = agpc_pkg::ST_CHARGE;
					end else begin
						s_nxt.st = agpc_pkg::ST_PRECHG;
						s_nxt.cnt = pre_t;
					end
				end
			end
			agpc_pkg::ST_GUARD: begin
				s_nxt.dly = 8'h00;
				if (fall) begin
					s_nxt.st = agpc_pkg::ST_OFF;
				end else if (s_r.cnt != 8'h00) begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end else if (adaptive_control_select == agpc_pkg::AGC_NONE || pre_t == 8'h00) begin
					s_nxt.st = agpc_pkg::ST_CHARGE;
				end else begin
					s_nxt.st = agpc_pkg::ST_PRECHG;
					s_nxt.cnt = pre_t;
				end
			end
			agpc_pkg::ST_PRECHG: begin
				pg.chg = 1'b1;
				pg.dis = 1'b0;
				// second half of a split phase runs at half the code
				pg.code = (s_r.ctrl[agpc_pkg::CTRL_SPLIT] && s_r.cnt <= (pre_t >> 1)) ? (pre_code >> 1) : pre_code;
				s_nxt.cnt = s_r.cnt - 8'h01;
				if (s_r.cnt == 8'h01 || s_r.cnt == 8'h00) begin
					s_nxt.st = agpc_pkg::ST_CHARGE;
				end
			end
			agpc_pkg::ST_CHARGE: begin
				pg = '{chg: 1'b1, dis: 1'b0, code: main_code};
				if (near_hit) begin
					s_nxt.st = agpc_pkg::ST_ON;
					s_nxt.eff_on = s_r.dly;
					cmp_on = compare(s_r.dly, s_r.target[agpc_pkg::TGT_ON +: 8]);
					s_nxt.hist_on = cmp_on;
					if (adaptive_control_select[1]) begin
						s_nxt.pre_cur = adapt(s_r.pre_cur, cmp_on, s_r.hist_on, s_r.ctrl[agpc_pkg::CTRL_FILT],
							s_r.ctrl[agpc_pkg::CTRL_STEP], maxc);
					end
					s_nxt.cnt = {2'b00, main_code};
				end
			end
			agpc_pkg::ST_ON: begin
				// post-charge ramps one step per clock up to the maximum
				pg = '{chg: 1'b1, dis: 1'b0, code: s_r.cnt[5:0]};
				if (s_r.cnt[5:0] < maxc) begin
					s_nxt.cnt = s_r.cnt + 8'h01;
				end
			end
			agpc_pkg::ST_SYM: begin
				pg = '{chg: 1'b1, dis: 1'b0, code: maxc};
				s_nxt.cnt = s_r.cnt - 8'h01;
				if (s_r.cnt == 8'h00) begin
					s_nxt.st = (adaptive_control_select == agpc_pkg::AGC_NONE || predis_t == 8'h00) ? agpc_pkg::ST_DISCHG : agpc_pkg::ST_PREDIS;
					s_nxt.cnt = predis_t;
					s_nxt.gcnt = guard_t;
					s_nxt.dly = 8'h00;
					s_nxt.crossed = 1'b0;
				end
			end
			agpc_pkg::ST_PREDIS: begin
				pg.code = (s_r.ctrl[agpc_pkg::CTRL_SPLIT] && s_r.cnt <= (predis_t >> 1)) ? (predis_code >> 1) : predis_code;
				s_nxt.cnt = s_r.cnt - 8'h01;
				s_nxt.gcnt = s_r.gcnt - 8'h01;
				if (s_r.cnt == 8'h01 || s_r.cnt == 8'h00) begin
					s_nxt.st = agpc_pkg::ST_DISCHG;
				end
			end
			agpc_pkg::ST_DISCHG: begin
				if (far_hit && !s_r.crossed) begin
					s_nxt.crossed = 1'b1;
					s_nxt.eff_off = s_r.dly;
				end
				if (s_r.gcnt != 8'h00) begin
					s_nxt.gcnt = s_r.gcnt - 8'h01;
				end else begin
					off_meas = s_r.crossed ? s_r.eff_off : s_r.dly;
					cmp_off = compare(off_meas, s_r.target[agpc_pkg::TGT_OFF +: 8]);
					s_nxt.st = agpc_pkg::ST_OFF;
					s_nxt.eff_off = off_meas;
					s_nxt.hist_off = cmp_off;
					if (adaptive_control_select[1]) begin
						s_nxt.predis_cur = adapt(s_r.predis_cur, cmp_off, s_r.hist_off, s_r.ctrl[agpc_pkg::CTRL_FILT],
							s_r.ctrl[agpc_pkg::CTRL_STEP], maxc);
					end
					s_nxt.match_on = match_step(s_r.match_on, cmp_on == 2'b00);
					s_nxt.match_off = match_step(s_r.match_off, cmp_off == 2'b00);
					s_nxt.flips_on = flip_step(s_r.flips_on, s_r.sign_on, cmp_on);
					s_nxt.flips_off = flip_step(s_r.flips_off, s_r.sign_off, cmp_off);
					if (cmp_on != 2'b00) begin
						s_nxt.sign_on = {1'b1, cmp_on[1]};
					end
					if (cmp_off != 2'b00) begin
						s_nxt.sign_off = {1'b1, cmp_off[1]};
					end
					// complementary gate charged only once the node has swung
					s_nxt.fw_on = s_r.ctrl[agpc_pkg::CTRL_AFW] && far_hit;
				end
			end
			default: s_nxt.st = agpc_pkg::ST_OFF;
		endcase

		// falling edge leaves any turn-on phase
		if (fall && (s_r.st == agpc_pkg::ST_PRECHG || s_r.st == agpc_pkg::ST_CHARGE || s_r.st == agpc_pkg::ST_ON)) begin
			s_nxt.cnt = guard_t;
			s_nxt.gcnt = guard_t;
			s_nxt.dly = 8'h00;
			s_nxt.crossed = 1'b0;
			if (s_r.ctrl[agpc_pkg::CTRL_AFW]) begin
				s_nxt.st = agpc_pkg::ST_SYM;
			end else begin
				s_nxt.cnt = predis_t;
				s_nxt.st = (adaptive_control_select == agpc_pkg::AGC_NONE || predis_t == 8'h00) ? agpc_pkg::ST_DISCHG : agpc_pkg::ST_PREDIS;
			end
		end

		s_nxt.in_reg = adaptive_control_select[1] && ((s_r.match_on >= agpc_pkg::MATCH_REG && s_r.match_off >= agpc_pkg::MATCH_REG)
			|| (s_r.flips_on == agpc_pkg::FLIPS_REG && s_r.flips_off == agpc_pkg::FLIPS_REG));

		if (!s_r.ctrl[agpc_pkg::CTRL_AFW]) begin
			fg = '{chg: 1'b0, dis: 1'b1, code: main_code};
			s_nxt.fw_on = 1'b0;
		end

		if (en_rise) begin
			s_nxt.pre_cur = (s_r.current[agpc_pkg::CUR_INIT_CHG +: 6] < maxc) ? s_r.current[agpc_pkg::CUR_INIT_CHG +: 6] : maxc;
			s_nxt.predis_cur = (s_r.current[agpc_pkg::CUR_INIT_DIS +: 6] < maxc) ? s_r.current[agpc_pkg::CUR_INIT_DIS +: 6] : maxc;
			s_nxt.match_on = 4'h0;
			s_nxt.match_off = 4'h0;
			s_nxt.flips_on = 2'h0;
			s_nxt.flips_off = 2'h0;
			s_nxt.sign_on = 2'h0;
			s_nxt.sign_off = 2'h0;
			s_nxt.hist_on = 2'h0;
			s_nxt.hist_off = 2'h0;
		end
		if (!s_r.ctrl[agpc_pkg::CTRL_ENABLE]) begin
			s_nxt.st = agpc_pkg::ST_OFF;
			s_nxt.fw_on = 1'b0;
			pg = '{chg: 1'b0, dis: 1'b1, code: main_code};
			fg = '{chg: 1'b0, dis: 1'b1, code: main_code};
		end

		// low-side mapping puts the PWM sequence on the low transistor
		s_nxt.hs = s_r.ctrl[agpc_pkg::CTRL_LOW_MAP] ? fg : pg;
		s_nxt.ls = s_r.ctrl[agpc_pkg::CTRL_LOW_MAP] ? pg : fg;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.ctrl <= agpc_pkg::CTRL_RESET;
			s_r.current <= agpc_pkg::CURRENT_RESET;
			s_r.timing <= agpc_pkg::TIMING_RESET;
			s_r.target <= agpc_pkg::TARGET_RESET;
			s_r.st <= agpc_pkg::ST_OFF;
			s_r.wait_r <= 1'b1;
			s_r.hs <= '{chg: 1'b0, dis: 1'b1, code: 6'h00};
			s_r.ls <= '{chg: 1'b0, dis: 1'b1, code: 6'h00};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_rsp = '{readdata: s_r.rdata, waitrequest: s_r.wait_r};
	assign hs_gate = s_r.hs;
	assign ls_gate = s_r.ls;

endmodule // agpc_top

// file: dv/agpc_chk.sv
`timescale 1ns/1ns
module agpc_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire agpc_pkg::agpc_av_req_type avs_req,
	input wire agpc_pkg::agpc_av_rsp_type avs_rsp,
	input wire logic pwm_in,
	input wire logic sw_node_high_in,
	input wire logic sw_node_low_in,
	input wire agpc_pkg::agpc_gate_type hs_gate,
	input wire agpc_pkg::agpc_gate_type ls_gate
);
	// ----
	// control shadow from bus writes
	// ----
	// age hides the short resync after a control write
	logic [7:0] ctrl_r;
	logic [7:0] guard_r;
	logic [2:0] age_r;
	logic acc;
	logic calm;
	assign acc = avs_req.write && !avs_rsp.waitrequest;
	assign calm = age_r == 3'h7;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_r <= agpc_pkg::CTRL_RESET;
			guard_r <= agpc_pkg::TIMING_RESET[23:16];
			age_r <= 3'h0;
		end else begin
			if (acc && avs_req.address == agpc_pkg::ADDR_CTRL) begin
				ctrl_r <= avs_req.writedata[7:0];
				age_r <= 3'h0;
			end else if (!calm) begin
				age_r <= age_r + 3'h1;
			end
			if (acc && avs_req.address == agpc_pkg::ADDR_TIMING) begin
				guard_r <= avs_req.writedata[23:16];
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----
	// properties
	// ----
	property p_wait_one;
		$fell(avs_rsp.waitrequest) |=> avs_rsp.waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait low longer than one cycle");
	property p_answer;
		(avs_req.read || avs_req.write) && avs_rsp.waitrequest |=> !avs_rsp.waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("access not answered after one wait cycle");
	property p_unmapped;
		avs_req.read && avs_req.address > 3'h4 && avs_rsp.waitrequest |=> avs_rsp.readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_passive;
		calm && !ctrl_r[1] && !ctrl_r[2] |-> !ls_gate.chg;
	endproperty
	a_passive: assert property (p_passive) else $error("complementary gate charged");
	property p_passive_ls;
		calm && !ctrl_r[1] && ctrl_r[2] |-> !hs_gate.chg;
	endproperty
	a_passive_ls: assert property (p_passive_ls) else $error("high gate charged in low map");
	property p_guard;
		calm && ctrl_r[1] && !ctrl_r[2] && guard_r > 8'h08 && $rose(pwm_in) |-> !hs_gate.chg [*8];
	endproperty
	a_guard: assert property (p_guard) else $error("charge inside guard interval");
	property p_skip_off;
		calm && !ctrl_r[1] && !ctrl_r[2] && $fell(pwm_in) && hs_gate.chg |-> ##[2:6] !hs_gate.chg;
	endproperty
	a_skip_off: assert property (p_skip_off) else $error("passive turn-off held back");
	property p_flag;
		calm && !ctrl_r[4] && avs_req.read && avs_req.address == agpc_pkg::ADDR_STATUS && avs_rsp.waitrequest
			|=> !avs_rsp.readdata[31];
	endproperty
	a_flag: assert property (p_flag) else $error("regulation flag outside adaptive mode");
endmodule // agpc_chk

// file: dv/agpc_bridge.sv
`timescale 1ns/1ns
module agpc_bridge (
	input wire logic clk,
	input wire logic low_map,
	input wire logic [7:0] slew,
	input wire agpc_pkg::agpc_gate_type hs_gate,
	input wire agpc_pkg::agpc_gate_type ls_gate,
	output logic sw_node_high_in,
	output logic sw_node_low_in
);
	// node follows the pwm transistor slew plus one cycles after its gate changes, body diode otherwise
	logic node_r = 1'b0;
	logic [7:0] cnt_r = 8'h00;
	logic want;
	assign want = low_map ? !ls_gate.chg : hs_gate.chg;
	always_ff @(posedge clk) begin
		if (want == node_r) begin
			cnt_r <= 8'h00;
		end else if (cnt_r >= slew) begin
			node_r <= want;
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	assign sw_node_high_in = node_r;
	assign sw_node_low_in = !node_r;
endmodule // agpc_bridge

// file: dv/testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
	logic clk;
	logic rst_n;
	agpc_pkg::agpc_av_req_type req;
	agpc_pkg::agpc_av_rsp_type rsp;
	logic pwm;
	logic swh;
	logic swl;
	agpc_pkg::agpc_gate_type hs;
	agpc_pkg::agpc_gate_type ls;
	logic low_map;
	logic [7:0] slew;
	logic [31:0] q;
	int num_errors;
	int check_count;
	agpc_top DUT (.clk(clk), .rst_n(rst_n), .avs_req(req), .avs_rsp(rsp), .pwm_in(pwm), .sw_node_high_in(swh),
		.sw_node_low_in(swl), .hs_gate(hs), .ls_gate(ls));
	agpc_bridge u_br (.clk(clk), .low_map(low_map), .slew(slew), .hs_gate(hs), .ls_gate(ls),
		.sw_node_high_in(swh), .sw_node_low_in(swl));
	// ----
	// bus and pwm drivers
	// ----
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		req.read <= !w;
		req.write <= w;
		req.address <= a;
		req.writedata <= d;
		@(posedge clk);
		while (rsp.waitrequest !== 1'b0) @(posedge clk);
		q = rsp.readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			pwm <= 1'b1;
			repeat (60) @(posedge clk);
			pwm <= 1'b0;
			repeat (60) @(posedge clk);
		end
	endtask
	task automatic lat(output int u, output int f);
		u = 0;
		f = 0;
		pwm <= 1'b1;
		while (hs.chg !== 1'b1 && u < 99) begin
			@(posedge clk);
			u++;
		end
		repeat (60) @(posedge clk);
		pwm <= 1'b0;
		while (hs.chg !== 1'b0 && f < 99) begin
			@(posedge clk);
			f++;
		end
		repeat (60) @(posedge clk);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_regs();
		logic [31:0] ev [5] = '{{24'h0, agpc_pkg::CTRL_RESET}, agpc_pkg::CURRENT_RESET, agpc_pkg::TIMING_RESET,
			agpc_pkg::TARGET_RESET, 32'h0};
		logic [2:0] av [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
		bus(1'b1, 3'h7, 32'hFFFF_FFFF);
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, av[i], 32'h0);
			`CHK("register", ev[i], q)
		end
		// reserved bits above each six-bit code must read back as zero
		bus(1'b1, 3'h1, 32'hFFFF_FFFF);
		bus(1'b0, 3'h1, 32'h0);
		`CHK("code mask", 32'h3F3F_3F3F, q)
		bus(1'b1, 3'h2, 32'h0010_0808);
	endtask
	task automatic t_adapt();
		bus(1'b1, 3'h1, 32'h1030_0520);
		bus(1'b1, 3'h0, 32'h1B);
		bus(1'b0, 3'h4, 32'h0);
		`CHK("predis load", 6'h20, q[21:16])
		`CHK("pre load", 6'h05, q[29:24])
		bus(1'b1, 3'h0, 32'h1A);
		bus(1'b1, 3'h1, 32'h101C_0520);
		bus(1'b1, 3'h0, 32'h1B);
		bus(1'b1, 3'h3, 32'h0000_010A);
		pulses(2);
		bus(1'b0, 3'h4, 32'h0);
		`CHK("step one", 6'h1E, q[21:16])
		bus(1'b1, 3'h0, 32'h5B);
		pulses(2);
		bus(1'b0, 3'h4, 32'h0);
		`CHK("clamped", 6'h20, q[21:16])
		bus(1'b1, 3'h3, 32'h0000_FA0A);
		pulses(1);
		bus(1'b0, 3'h4, 32'h0);
		`CHK("step down", 6'h1E, q[21:16])
	endtask
	task automatic t_filt();
		logic [6:0] pat = 7'h65;
		logic [5:0] ex [7] = '{6'h1C, 6'h1C, 6'h1C, 6'h1C, 6'h1B, 6'h1B, 6'h1C};
		bus(1'b1, 3'h0, 32'h1A);
		bus(1'b1, 3'h0, 32'h3B);
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, 3'h3, pat[i] ? 32'h0000_010A : 32'h0000_FA0A);
			pulses(1);
			bus(1'b0, 3'h4, 32'h0);
			`CHK("filtered", ex[i], q[21:16])
		end
	endtask
	task automatic t_afw();
		int u1;
		int f1;
		int u0;
		int f0;
		bus(1'b1, 3'h0, 32'h1B);
		lat(u1, f1);
		`CHK("freewheel on", 1'b1, ls.chg)
		bus(1'b1, 3'h0, 32'h19);
		lat(u0, f0);
		`CHK("freewheel off", 1'b0, ls.chg)
		`CHK("rise guard", 32'h11, u1 - u0)
		`CHK("fall hold", 32'h11, f1 - f0)
		bus(1'b1, 3'h0, 32'h1D);
		low_map <= 1'b1;
		pwm <= 1'b1;
		repeat (30) @(posedge clk);
		`CHK("low map gates", 4'h9, {ls.chg, ls.dis, hs.chg, hs.dis})
		pwm <= 1'b0;
		repeat (60) @(posedge clk);
		low_map <= 1'b0;
		bus(1'b1, 3'h0, 32'h1B);
	endtask
	task automatic t_modes();
		logic [7:0] cv [3] = '{8'h09, 8'h89, 8'h01};
		logic [5:0] e0 [3] = '{6'h05, 6'h05, 6'h10};
		logic [5:0] e1 [3] = '{6'h05, 6'h02, 6'h10};
		int n;
		slew <= 8'h14;
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, 3'h0, {24'h0, cv[i]});
			pwm <= 1'b1;
			n = 0;
			while (hs.chg !== 1'b1 && n < 99) begin
				@(posedge clk);
				n++;
			end
			`CHK("first code", e0[i], hs.code)
			repeat (7) @(posedge clk);
			`CHK("late code", e1[i], hs.code)
			repeat (60) @(posedge clk);
			pwm <= 1'b0;
			repeat (60) @(posedge clk);
		end
		slew <= 8'h06;
	endtask
	task automatic t_regu();
		logic [31:0] t;
		bus(1'b1, 3'h0, 32'h1B);
		pulses(1);
		bus(1'b0, 3'h4, 32'h0);
		// measured delays become the targets so every cycle matches
		t = {16'h0, q[15:0]};
		bus(1'b1, 3'h3, t);
		bus(1'b1, 3'h0, 32'h1A);
		bus(1'b1, 3'h0, 32'h1B);
		pulses(7);
		bus(1'b0, 3'h4, 32'h0);
		`CHK("flag early", 1'b0, q[31])
		pulses(1);
		bus(1'b0, 3'h4, 32'h0);
		`CHK("flag", 1'b1, q[31])
		bus(1'b1, 3'h0, 32'h1A);
		bus(1'b1, 3'h0, 32'h1B);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 3'h3, i[0] ? t + 32'h0101 : t - 32'h0101);
			pulses(1);
			bus(1'b0, 3'h4, 32'h0);
			if (i == 3) `CHK("flips", 1'b1, q[31])
		end
		bus(1'b1, 3'h0, 32'h0B);
		pulses(1);
		bus(1'b0, 3'h4, 32'h0);
		`CHK("flag off", 1'b0, q[31])
		`CHK("delays kept", t[15:0], q[15:0])
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		num_errors = 0;
		check_count = 0;
		rst_n = 1'b0;
		req = '0;
		pwm = 1'b0;
		low_map = 1'b0;
		slew = 8'h06;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_adapt();
		t_filt();
		t_afw();
		t_modes();
		t_regu();
		final_report();
	end
	// about 4000 cycles expected, limit at 20000 cycles, five times that
	initial begin
		#2_000_000;
		num_errors++;
		final_report();
	end
endmodule // testbench
bind agpc_top agpc_chk u_chk (.clk(clk), .rst_n(rst_n), .avs_req(avs_req), .avs_rsp(avs_rsp), .pwm_in(pwm_in),
	.sw_node_high_in(sw_node_high_in), .sw_node_low_in(sw_node_low_in), .hs_gate(hs_gate), .ls_gate(ls_gate));
